// >>> logic/wiper_host_regs.vh
// Constants for the wiper position host controller
`ifndef WIPER_HOST_REGS_VH
`define WIPER_HOST_REGS_VH

`define CLK_PERIOD_NS     10
`define T_CS_SETUP_NS     100
`define T_DIR_SETUP_NS    1000
`define T_STEP_LOW_NS     1000
`define T_STEP_HIGH_NS    1000
`define T_LOCK_SETUP_NS   1000
`define T_DIR_HOLD_NS     100
// Cycle counts at 10 ns per clock, sized for the 8-bit timer
`define CYC_CS_SETUP   8'h0a
`define CYC_DIR_SETUP  8'h64
`define CYC_STEP_LOW   8'h64
`define CYC_STEP_HIGH  8'h64
`define CYC_LOCK_SETUP 8'h64
`define CYC_DIR_HOLD   8'h0a
`define POS_WIDTH      7
`define POS_MIDSCALE   7'h40
`define POS_MAX        7'h7f
`define POS_MIN        7'h00
`define CNT_WIDTH      8

`endif

// >>> logic/wiper_host.v
// Host controller driving the three control pins of an up/down wiper counter
`timescale 1ns/1ps
`default_nettype none
`include "wiper_host_regs.vh"

module wiper_host (
  input  wire       core_clk,   // 100 MHz clock
  input  wire       rst,        // Synchronous reset, active high
  input  wire       cmd_valid,  // Request a step burst
  input  wire       cmd_up,     // Burst direction, 1 = up
  input  wire [6:0] cmd_steps,  // Number of steps, 0 = none
  input  wire       cmd_lock,   // End burst by locking the wiper
  output wire       cmd_ready,  // Idle and not locked
  output reg        step_n_q,   // Step strobe pin, falls to step
  output reg        dir_q,      // Direction pin
  output reg        sel_n_q,    // Select pin, active low
  output reg  [6:0] pos_q,      // Shadow of the device wiper position
  output reg        locked_q,   // Device wiper locked
  output reg        done_q      // Pulse when a burst ends
);

  localparam [6:0] S_IDLE  = 7'b000_0001;
  localparam [6:0] S_SETUP = 7'b000_0010;
  localparam [6:0] S_LOW   = 7'b000_0100;
  localparam [6:0] S_HIGH  = 7'b000_1000;
  localparam [6:0] S_LOCK  = 7'b001_0000;
  localparam [6:0] S_REL   = 7'b010_0000;
  localparam [6:0] S_HOLD  = 7'b100_0000;

  reg [6:0]              state_q;
  reg [6:0]              state_d;
  reg [`CNT_WIDTH-1:0]   timer_q;
  reg [`CNT_WIDTH-1:0]   timer_d;
  reg [6:0]              left_q;
  reg [6:0]              left_d;
  reg                    lock_req_q;
  reg                    lock_req_d;
  reg                    step_n_d;
  reg                    dir_d;
  reg                    sel_n_d;
  reg [6:0]              pos_d;
  reg                    locked_d;
  reg                    done_d;
  wire                   timer_done;

  assign timer_done = (timer_q == 8'h00);

  assign cmd_ready = state_q[0] & ~locked_q;

  always @* begin
    state_d    = state_q;
    timer_d    = timer_q;
    left_d     = left_q;
    lock_req_d = lock_req_q;
    step_n_d   = step_n_q;
    dir_d      = dir_q;
    sel_n_d    = sel_n_q;
    pos_d      = pos_q;
    locked_d   = locked_q;
    done_d     = 1'b0;
    if (!timer_done)
      timer_d = timer_q - 8'h01;
    case (state_q)
      S_IDLE: begin
        // Pins stay parked high, so the device sits in standby
        sel_n_d  = 1'b1;
        step_n_d = 1'b1;
        if (cmd_valid && !locked_q) begin
          if (cmd_steps == 7'h00 && !cmd_lock) begin
            // Nothing to move: raising select with strobe high would lock
            done_d = 1'b1;
          end else begin
            // Direction set while strobe is high, in the same cycle as select falls, well ahead of the first strobe fall
            dir_d      = cmd_up;
            sel_n_d    = 1'b0;
            left_d     = cmd_steps;
            lock_req_d = cmd_lock;
            timer_d    = `CYC_DIR_SETUP;
            state_d    = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        if (timer_done) begin
          if (left_q == 7'h00) begin
            timer_d = `CYC_LOCK_SETUP;
            state_d = S_LOCK;
          end else begin
            step_n_d = 1'b0;
            timer_d  = `CYC_STEP_LOW;
            state_d  = S_LOW;
            if (dir_q && pos_q != `POS_MAX)
              pos_d = pos_q + 7'h01;
            else if (!dir_q && pos_q != `POS_MIN)
              pos_d = pos_q - 7'h01;
            left_d = left_q - 7'h01;
          end
        end
      end
      S_LOW: begin
        if (timer_done) begin
          if (left_q == 7'h00 && !lock_req_q) begin
            // Select rises with strobe still low so no lock occurs
            sel_n_d = 1'b1;
            timer_d = `CYC_CS_SETUP;
            state_d = S_REL;
          end else begin
            step_n_d = 1'b1;
            timer_d  = `CYC_STEP_HIGH;
            state_d  = S_HIGH;
          end
        end
      end
      S_HIGH: begin
        if (timer_done) begin
          if (left_q == 7'h00) begin
            timer_d = `CYC_LOCK_SETUP;
            state_d = S_LOCK;
          end else begin
            timer_d = 8'h00;
            state_d = S_SETUP;
          end
        end
      end
      S_LOCK: begin
        // Strobe high long enough, now raise select to freeze wiper
        if (timer_done) begin
          sel_n_d  = 1'b1;
          locked_d = 1'b1;
          done_d   = 1'b1;
          state_d  = S_HOLD;
        end
      end
      S_REL: begin
        // Select is already high here; strobe may now rise safely
        if (timer_done) begin
          step_n_d = 1'b1;
          done_d   = 1'b1;
          state_d  = S_IDLE;
        end
      end
      S_HOLD: begin
        // Locked device ignores the pins, so park them idle
        sel_n_d  = 1'b1;
        step_n_d = 1'b1;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_q    <= S_IDLE;
      timer_q    <= 8'h00;
      left_q     <= 7'h00;
      lock_req_q <= 1'b0;
      step_n_q   <= 1'b1;
      sel_n_q    <= 1'b1;
      dir_q      <= 1'b1;
      pos_q      <= `POS_MIDSCALE;
      locked_q   <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      timer_q    <= timer_d;
      left_q     <= left_d;
      lock_req_q <= lock_req_d;
      step_n_q   <= step_n_d;
      sel_n_q    <= sel_n_d;
      dir_q      <= dir_d;
      pos_q      <= pos_d;
      locked_q   <= locked_d;
      done_q     <= done_d;
    end
  end

endmodule // wiper_host

`default_nettype wire

// >>> tb/wiper_host_props.sv
// Pin checks for the wiper host
`timescale 1ns/1ps
`default_nettype none
module wiper_host_props (
  input wire logic       core_clk,  // Clock
  input wire logic       rst,       // Reset
  input wire logic       cmd_ready, // Idle
  input wire logic       step_n_q,  // Strobe
  input wire logic       dir_q,     // Direction
  input wire logic       sel_n_q,   // Select
  input wire logic [6:0] pos_q,     // Shadow
  input wire logic       locked_q   // Locked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_init; $fell(rst) |-> sel_n_q && step_n_q && pos_q == 7'h40
    && !locked_q; endproperty
  a_init: assert property (p_init) else $error("bad reset");
  property p_sel; $fell(step_n_q) |-> !sel_n_q; endproperty
  a_sel: assert property (p_sel) else $error("unselected step");
  property p_up; $fell(step_n_q) && dir_q && $past(pos_q) != 7'h7f
    |-> pos_q == $past(pos_q) + 7'h01; endproperty
  a_up: assert property (p_up) else $error("no step up");
  property p_dn; $fell(step_n_q) && !dir_q && $past(pos_q) != 7'h00
    |-> pos_q == $past(pos_q) - 7'h01; endproperty
  a_dn: assert property (p_dn) else $error("no step down");
  property p_sat; $fell(step_n_q) && $past(pos_q) == {7{dir_q}}
    |-> $stable(pos_q); endproperty
  a_sat: assert property (p_sat) else $error("wrapped");
  property p_hold; !$fell(step_n_q) |-> $stable(pos_q); endproperty
  a_hold: assert property (p_hold) else $error("moved idle");
  property p_end; $rose(sel_n_q) |-> !step_n_q || locked_q; endproperty
  a_end: assert property (p_end) else $error("unwanted lock");
  property p_lock; locked_q |-> !cmd_ready ##1 locked_q; endproperty
  a_lock: assert property (p_lock) else $error("lock lost");
endmodule // wiper_host_props
bind wiper_host wiper_host_props props_u (.core_clk(core_clk), .rst(rst),
  .cmd_ready(cmd_ready), .step_n_q(step_n_q), .dir_q(dir_q),
  .sel_n_q(sel_n_q), .pos_q(pos_q), .locked_q(locked_q));
`default_nettype wire

// >>> tb/wiper_dev.sv
// Behavioural up/down wiper counter
`timescale 1ns/1ps
`default_nettype none
module wiper_dev (
  input  wire logic       por,    // Power-on
  input  wire logic       step_n, // Strobe
  input  wire logic       dir,    // Direction
  input  wire logic       sel_n,  // Select
  output var  logic [6:0] pos     // Count
);
  logic         lock;
  logic [127:0] tap;
  assign tap = 128'h1 << pos;
  always @(posedge por, negedge step_n, posedge sel_n, negedge sel_n) begin
    if (por) begin
      pos = 7'h40;
      lock = 1'b0;
    end else if (!lock && sel_n && step_n) begin
      lock = 1'b1;
    end else if (!lock && !sel_n && !step_n) begin
      if (dir && pos != 7'h7f) pos = pos + 7'h01;
      else if (!dir && pos != 7'h00) pos = pos - 7'h01;
    end
  end
endmodule // wiper_dev
`default_nettype wire

// >>> tb/wiper_host_tb.sv
// Random and corner bursts against the wiper model
`timescale 1ns/1ps
`default_nettype none
module wiper_host_tb;
  logic       core_clk, rst, cmd_valid, cmd_up, cmd_lock;
  logic [6:0] cmd_steps, dev_pos, exp;
  wire        cmd_ready, step_n_q, dir_q, sel_n_q, locked_q, done_q;
  wire  [6:0] pos_q;
  integer     seed, mismatches, num_checks, cyc, i;
  wiper_host dut_u (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_up(cmd_up), .cmd_steps(cmd_steps), .cmd_lock(cmd_lock),
    .cmd_ready(cmd_ready), .step_n_q(step_n_q), .dir_q(dir_q),
    .sel_n_q(sel_n_q), .pos_q(pos_q), .locked_q(locked_q), .done_q(done_q));
  wiper_dev dev_u (.por(rst), .step_n(step_n_q), .dir(dir_q),
    .sel_n(sel_n_q), .pos(dev_pos));
  function automatic logic [6:0] walk(logic [6:0] p, logic up, logic [6:0] n);
    for (int k = 0; k < n; k++)
      p = up ? (p == 7'h7f ? p : p + 7'h01) : (p == 7'h00 ? p : p - 7'h01);
    return p;
  endfunction
  task check(input logic [6:0] seen, input logic [6:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("Error t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task burst(input logic up, input logic [6:0] n, input logic lk);
    exp = walk(exp, up, n);
    @(posedge core_clk);
    {cmd_valid, cmd_up, cmd_steps, cmd_lock} <= {1'b1, up, n, lk};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    // Bounded wait, sampled away from the launching edge
    for (int w = 0; w < 50000 && done_q !== 1'b1; w++) @(negedge core_clk);
    check({6'h00, done_q}, 7'h01);
    check(pos_q, exp);
    check({6'h00, dev_u.tap[exp]}, 7'h01);
    check(dev_pos, exp);
    check({6'h00, locked_q}, {6'h00, lk});
    $display("burst up %0d steps %0d done", up, n);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 80000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    rst <= 1'b1;
    {cmd_valid, cmd_up, cmd_steps, cmd_lock} <= 10'h000;
    {seed, mismatches, num_checks, cyc, exp} = {32'd64, 96'd0, 7'h40};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    burst(1'b1, 7'h41, 1'b0);
    for (i = 0; i < 3; i++)
      burst(1'($random(seed)), 7'($random(seed) & 15), 1'b0);
    burst(1'b0, 7'h7f, 1'b0);
    burst(1'b1, 7'h03, 1'b1);
    check({6'h00, cmd_ready}, 7'h00);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    exp = 7'h40;
    @(negedge core_clk);
    check(dev_pos, 7'h40);
    check(pos_q, 7'h40);
    check({6'h00, locked_q, cmd_ready}, 7'h01);
    burst(1'b0, 7'h01, 1'b0);
    wrap_up;
  end
endmodule // wiper_host_tb
`default_nettype wire
